// File: hw/sbw_core.sv
/*
 * sleep button, wake and power button override logic of the aux plane.
 * assumes the power state comes from the power manager on mclk_i and
 * that the button, thermal and usb resume inputs are asynchronous pins.
 */
// Overview of operation
// - debounce sleep button about sixteen milliseconds
// - press sets flag and may wake system
// - four second hold outside soft-off overrides
// - override deasserts main power, sets flag
// - pin may serve as general io three
// - soft reset clears aux bits thirty milliseconds
// - usb resume in sleep sets flag
// - thermal warning throttles when enabled
// - suspend output follows power control bit
// - main power on in active states only
`timescale 1ns/1ps
`default_nettype none
module sbw_core
  import sbw_pkg::*;
#(
  parameter int unsigned RTC_DIV = SBW_RTC_DIV,
  parameter int unsigned HOLD_TICKS = SBW_HOLD_TICKS,
  parameter int unsigned SOFT_RST_TICKS = SBW_SOFT_RST_TICKS,
  parameter int unsigned DEBOUNCE_TICKS = SBW_DEBOUNCE_TICKS
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // pins
  input wire logic sleep_button_n_i,
  input wire logic thermal_warning_n_i,
  input wire logic usb_resume_i,
  // power manager side
  input wire sbw_pstate_t pstate_i,
  input wire sbw_ctrl_t ctrl_i,
  input wire logic [2:0] flag_clear_i,  // write-one-to-clear pulses
  // outputs
  output sbw_status_t status_o,
  output logic wake_req_o,
  output logic main_power_on_n_o,
  output logic suspend_n_o,
  output logic throttle_o,
  output logic [2:0] throttle_ratio_o,
  output logic general_io_three_o,
  output logic soft_rst_o
);

  // ****************************************************************
  // rtc tick divider
  // ****************************************************************
  logic [15:0] div_cnt;  // mclk cycles within one rtc period
  wire rtc_tick = (div_cnt == 16'(RTC_DIV - 1));

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) div_cnt <= '0;
    else div_cnt <= rtc_tick ? '0 : div_cnt + 1'b1;
  end

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [2:0] sync1;  // first stage, read only by sync2
  logic [2:0] sync2;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1 <= 3'h3;
      sync2 <= 3'h3;
    end else begin
      sync1 <= {usb_resume_i, thermal_warning_n_i, sleep_button_n_i};
      sync2 <= sync1;
    end
  end

  wire btn_raw_n = sync2[0];
  wire thermal_warning_n_n = sync2[1];
  wire usb_rsm = sync2[2];

  // ****************************************************************
  // aux soft reset
  // ****************************************************************
  logic [SBW_CNT_W-1:0] srst_cnt;  // ticks since aux power valid
  wire srst_done = (srst_cnt == SBW_CNT_W'(SOFT_RST_TICKS));

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) srst_cnt <= '0;
    else if (rtc_tick && !srst_done) srst_cnt <= srst_cnt + 1'b1;
  end

  // register bits are held clear while soft reset is high
  assign soft_rst_o = !srst_done;

  // ****************************************************************
  // debounce
  // ****************************************************************
  logic btn_n;  // filtered button level
  wire btn_pin_n = ctrl_i.pin3_function_config ? 1'b1 : btn_raw_n;

  sbw_debounce #(
    .TICKS(DEBOUNCE_TICKS)
  ) u_deb (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .tick_i(rtc_tick),
    .level_i(btn_pin_n),
    .level_o(btn_n)
  );

  // general io read path, registered
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) general_io_three_o <= 1'b1;
    else general_io_three_o <= ctrl_i.pin3_function_config ? btn_raw_n : 1'b1;
  end

  // ****************************************************************
  // press detect and hold timer
  // ****************************************************************
  logic btn_n_d;                   // delayed filtered level
  logic [SBW_CNT_W-1:0] hold_cnt;  // ticks held while pressed
  logic hold_fired;                // one override per press
  wire press = btn_n_d && !btn_n;
  wire in_soft_off = (pstate_i == SBW_SOFT_OFF);
  wire sleeping = (pstate_i == SBW_STR) || (pstate_i == SBW_STD) ||
                  (pstate_i == SBW_POS) || in_soft_off;
  wire override_ev = !btn_n && !in_soft_off && !hold_fired && rtc_tick &&
                     (hold_cnt == SBW_CNT_W'(HOLD_TICKS - 1));

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      btn_n_d <= 1'b1;
      hold_cnt <= '0;
      hold_fired <= 1'b0;
    end else begin
      btn_n_d <= btn_n;
      if (btn_n || in_soft_off) begin
        hold_cnt <= '0;
        hold_fired <= 1'b0;
      end else if (override_ev) begin
        hold_fired <= 1'b1;
      end else if (rtc_tick && !hold_fired) begin
        hold_cnt <= hold_cnt + 1'b1;
      end
    end
  end

  // ****************************************************************
  // status flags: set wins over clear
  // ****************************************************************
  // usb resume in sleep
  wire usb_ev = usb_rsm && sleeping;
  wire [2:0] set_v = {press, override_ev, usb_ev};
  logic [2:0] flags;
  wire [2:0] next_flags = set_v | (flags & ~flag_clear_i);

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) flags <= SBW_FLAGS_RST;
    else if (!srst_done) flags <= SBW_FLAGS_RST;
    else flags <= next_flags;
  end

  assign status_o = '{sleep_button_flag: flags[2], override_flag: flags[1],
                      usb_resume_flag: flags[0]};

  // ****************************************************************
  // wake, main power, suspend, throttle
  // ****************************************************************
  logic ovr_off;  // override holds main power off
  wire active = (pstate_i == SBW_FULL_ON) || (pstate_i == SBW_C2) ||
                (pstate_i == SBW_C3) || (pstate_i == SBW_POS);

  // override latch ends once the manager reaches soft-off
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) ovr_off <= 1'b0;
    else if (override_ev) ovr_off <= 1'b1;
    else if (in_soft_off) ovr_off <= 1'b0;
  end

  // registered outputs
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      main_power_on_n_o <= 1'b0;
      wake_req_o <= 1'b0;
      suspend_n_o <= 1'b1;
      throttle_o <= 1'b0;
      throttle_ratio_o <= 3'h0;
    end else begin
      main_power_on_n_o <= !(active && !ovr_off && !override_ev);
      wake_req_o <= press && ctrl_i.wake_enable && sleeping && !in_soft_off;
      suspend_n_o <= !ctrl_i.suspend_ctl;
      throttle_o <= ctrl_i.throttle_enable && !thermal_warning_n_n;
      throttle_ratio_o <= ctrl_i.throttle_ratio;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  // cycles held outside soft-off, counted apart from the tick timer
  int unsigned held_cyc;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) held_cyc <= 0;
    else held_cyc <= (btn_n || in_soft_off) ? 0 : held_cyc + 1;
  end
  // override lands after hold-1 to hold rtc periods of holding
  property p_hold_override;
    @(posedge mclk_i) disable iff (!rst_n_i)
    override_ev |-> held_cyc >= (HOLD_TICKS - 1) * RTC_DIV &&
                    held_cyc < HOLD_TICKS * RTC_DIV;
  endproperty
  a_hold_override: assert property (p_hold_override) else $error("override bad");

  property p_power_off;
    @(posedge mclk_i) disable iff (!rst_n_i)
    override_ev |=> main_power_on_n_o && flags[1];
  endproperty
  a_power_off: assert property (p_power_off) else $error("power not off");

  property p_press_flag;
    @(posedge mclk_i) disable iff (!rst_n_i)
    press && srst_done |=> flags[2];
  endproperty
  a_press_flag: assert property (p_press_flag) else $error("press flag lost");

  property p_usb_flag;
    @(posedge mclk_i) disable iff (!rst_n_i)
    usb_ev && srst_done |=> status_o.usb_resume_flag;
  endproperty
  a_usb_flag: assert property (p_usb_flag) else $error("usb flag lost");

  property p_throttle;
    @(posedge mclk_i) disable iff (!rst_n_i)
    throttle_o |-> $past(ctrl_i.throttle_enable) && !$past(thermal_warning_n_n);
  endproperty
  a_throttle: assert property (p_throttle) else $error("throttle bad");

  property p_suspend;
    @(posedge mclk_i) disable iff (!rst_n_i)
    ##1 suspend_n_o == !$past(ctrl_i.suspend_ctl);
  endproperty
  a_suspend: assert property (p_suspend) else $error("suspend bad");

  property p_main_off;
    @(posedge mclk_i) disable iff (!rst_n_i)
    !active |=> main_power_on_n_o;
  endproperty
  a_main_off: assert property (p_main_off) else $error("power on in sleep");

  property p_soft_rst;
    @(posedge mclk_i) disable iff (!rst_n_i)
    soft_rst_o |=> flags == SBW_FLAGS_RST;
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("flags in reset");

  // cycles since the last tick, kept apart from the divider
  int unsigned tick_gap;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) tick_gap <= 0;
    else tick_gap <= rtc_tick ? 0 : tick_gap + 1;
  end
  property p_tick;
    @(posedge mclk_i) disable iff (!rst_n_i)
    rtc_tick == (tick_gap == RTC_DIV - 1);
  endproperty
  a_tick: assert property (p_tick) else $error("tick spacing bad");

  property p_gpio;
    @(posedge mclk_i) disable iff (!rst_n_i)
    ctrl_i.pin3_function_config |=> !press && general_io_three_o == $past(btn_raw_n);
  endproperty
  a_gpio: assert property (p_gpio) else $error("gpio leaks");

  c_override: cover property (@(posedge mclk_i) override_ev);
  c_press: cover property (@(posedge mclk_i) press);
  c_wake: cover property (@(posedge mclk_i) wake_req_o);
  c_usb: cover property (@(posedge mclk_i) usb_ev);

endmodule
`default_nettype wire

// File: hw/sbw_pkg.sv
/*
 * package for the sleep button / wake / override block: power state
 * encodings, timing figures and the carriers between the block and
 * the rest of the power manager.
 * assumes a 40 MHz mclk_i and a 32.768 kHz rtc tick made from it.
 */
package sbw_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int unsigned SBW_MCLK_HZ = 40000000;   // main clock rate
  localparam int unsigned SBW_RTC_HZ = 32768;       // rtc tick rate
  // rtc tick divider, rounded down so the tick is never slow
  localparam int unsigned SBW_RTC_DIV = SBW_MCLK_HZ / SBW_RTC_HZ;
  localparam int unsigned SBW_DEBOUNCE_MS = 16;     // stable time
  localparam int unsigned SBW_HOLD_S = 4;           // override hold
  localparam int unsigned SBW_SOFT_RST_MS = 30;     // aux soft reset
  // figures in rtc ticks, rounded up to whole ticks
  localparam int unsigned SBW_DEBOUNCE_TICKS =
    (SBW_DEBOUNCE_MS * SBW_RTC_HZ + 999) / 1000;
  localparam int unsigned SBW_HOLD_TICKS = SBW_HOLD_S * SBW_RTC_HZ;
  localparam int unsigned SBW_SOFT_RST_TICKS =
    (SBW_SOFT_RST_MS * SBW_RTC_HZ + 999) / 1000;
  localparam int unsigned SBW_CNT_W = 18;           // counter width

  // ****************************************************************
  // power states
  // ****************************************************************
  typedef enum logic [2:0] {
    SBW_FULL_ON = 3'h0,   // full_on_state
    SBW_C2 = 3'h1,
    SBW_C3 = 3'h3,
    SBW_POS = 3'h2,       // powered-on suspend
    SBW_STR = 3'h6,       // suspend to ram
    SBW_STD = 3'h7,       // suspend to disk
    SBW_SOFT_OFF = 3'h5   // soft_off_state
  } sbw_pstate_t;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic throttle_enable;      // allow throttling on thermal warning
    logic [2:0] throttle_ratio; // duty setting passed to the cpu
    logic suspend_ctl;          // suspend output request
    logic pin3_function_config; // 1: pin acts as general io
    logic wake_enable;          // sleep button may wake the system
  } sbw_ctrl_t;

  typedef struct packed {
    logic sleep_button_flag;
    logic override_flag;
    logic usb_resume_flag;
  } sbw_status_t;

  localparam logic [2:0] SBW_FLAGS_RST = 3'h0;  // flags after reset

endpackage

// File: hw/sbw_debounce.sv
/*
 * stability filter: the output follows the input only after the input
 * has held one level for the given count of enable ticks.
 * assumes the input is already synchronised to mclk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module sbw_debounce
  import sbw_pkg::*;
#(
  parameter int unsigned TICKS = SBW_DEBOUNCE_TICKS
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // sampling
  input wire logic tick_i,
  input wire logic level_i,
  // filtered level, idles high (button released)
  output logic level_o
);

  // ****************************************************************
  // stable-time counter
  // ****************************************************************
  logic [SBW_CNT_W-1:0] cnt;  // ticks the input has differed
  wire differs = (level_i != level_o);
  wire done = (cnt >= SBW_CNT_W'(TICKS - 1));

  // restart whenever the input bounces back
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= '0;
      level_o <= 1'b1;
    end else if (!differs) begin
      cnt <= '0;
    end else if (tick_i) begin
      if (done) begin
        level_o <= level_i;
        cnt <= '0;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// File: verif/sbw_board.sv
/*
 * board model: sleep button with pull-up and the main supply that
 * follows the active-low power enable.
 * assumes the bench clocks it with mclk_i and drives press_i.
 */
`timescale 1ns/1ps
`default_nettype none
module sbw_board (
  // clock
  input wire logic mclk_i,
  // board side
  input wire logic press_i,
  input wire logic main_power_on_n_i,
  // to the block and the bench
  output logic sleep_button_n_o,
  output logic power_ok_o
);
  logic [1:0] ramp = 2'h0;  // supply ramp counter

  // released button: the pull-up takes the pin high
  assign sleep_button_n_o = press_i ? 1'b0 : 1'b1;

  // supply needs a few cycles to come up, drops at once
  always_ff @(posedge mclk_i) begin
    if (main_power_on_n_i) begin
      ramp <= 2'h0;
    end else if (ramp != 2'h3) begin
      ramp <= ramp + 2'h1;
    end
  end
  assign power_ok_o = (ramp == 2'h3);
endmodule
`default_nettype wire

// File: verif/sleep_button_wake_override_test.sv
/*
 * self-checking bench for sbw_core, with a button and power model.
 * assumes shortened timing: 4 cycles a tick, 4 debounce, 20 hold ticks.
 */
`timescale 1ns/1ps
`default_nettype none
module sleep_button_wake_override_test;
  import sbw_pkg::*;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic press = 1'b0;
  logic btn_n, pwr_ok, thermal_warning_n_n = 1'b1, usb_rsm = 1'b0;
  sbw_pstate_t pstate = SBW_FULL_ON;
  sbw_ctrl_t ctrl = '0;
  logic [2:0] clr = 3'h0;
  sbw_status_t status;
  logic wake, pon_n, susp_n, thr, gio, srst;
  logic [2:0] ratio;
  int fails = 0;
  int n_checks = 0;
  int wakes[$];  // states in which a wake pulse was seen
  sbw_pstate_t states[7] = '{SBW_FULL_ON, SBW_C2, SBW_C3, SBW_POS, SBW_STR, SBW_STD, SBW_SOFT_OFF};

  sbw_board board (.mclk_i(mclk), .press_i(press), .main_power_on_n_i(pon_n),
    .sleep_button_n_o(btn_n), .power_ok_o(pwr_ok));
  sbw_core #(.RTC_DIV(4), .HOLD_TICKS(20), .SOFT_RST_TICKS(3), .DEBOUNCE_TICKS(4)) dut (
    .mclk_i(mclk), .rst_n_i(rst_n), .sleep_button_n_i(btn_n),
    .thermal_warning_n_i(thermal_warning_n_n), .usb_resume_i(usb_rsm), .pstate_i(pstate),
    .ctrl_i(ctrl), .flag_clear_i(clr), .status_o(status), .wake_req_o(wake),
    .main_power_on_n_o(pon_n), .suspend_n_o(susp_n), .throttle_o(thr),
    .throttle_ratio_o(ratio), .general_io_three_o(gio), .soft_rst_o(srst));

  // 40 MHz clock
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  // wake pulses stand one cycle: look mid-cycle, where they are settled
  always @(negedge mclk) begin
    if (wake === 1'b1) wakes.push_back(int'(pstate));
  end
  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // bounded wait, so a dead flag ends in a mismatch not a hang
  task automatic wait_flag(input int i, input int lim);
    int k;
    k = 0;
    while (status[i] !== 1'b1 && k < lim) begin
      @(negedge mclk);
      k++;
    end
  endtask
  task automatic clear(input logic [2:0] m);
    clr = m;
    cyc(1);
    clr = 3'h0;
    cyc(2);
  endtask
  // model: supply is off only in the deep sleep states
  function automatic logic exp_pon_n(input sbw_pstate_t s);
    return (s == SBW_STR || s == SBW_STD || s == SBW_SOFT_OFF);
  endfunction
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // watchdog, the tests need about 900 cycles
  initial begin
    #(25 * 20000);
    fails++;
    report_and_stop();
  end
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    void'($urandom(78));
    cyc(4);
    chk("pon_rst", 8'h0, pon_n);
    chk("susp_rst", 8'h1, susp_n);
    chk("flags_rst", 8'h0, status);
    chk("srst_on", 8'h1, srst);
    chk("gio_rst", 8'h1, gio);
    chk("thr_rst", 8'h0, thr);
    // usb resume while the soft reset still runs must be dropped
    pstate = SBW_STR;
    usb_rsm = 1'b1;
    rst_n = 1'b1;
    cyc(6);
    chk("srst_mid", 8'h1, srst);
    chk("usb_srst", 8'h0, status[0]);
    usb_rsm = 1'b0;
    pstate = SBW_FULL_ON;
    cyc(34);
    chk("srst_off", 8'h0, srst);
    chk("usb_after", 8'h0, status[0]);
    $display("test reset done");
    // short glitch must not pass, a held press must
    pstate = SBW_POS;
    ctrl.wake_enable = 1'b1;
    press = 1'b1;
    cyc(6);
    press = 1'b0;
    cyc(40);
    chk("glitch", 8'h0, status[2]);
    press = 1'b1;
    wait_flag(2, 60);
    cyc(3);
    press = 1'b0;
    chk("press_flag", 8'h1, status[2]);
    chk("wakes", 8'h1, 8'(wakes.size()));
    chk("wake_state", 8'(SBW_POS), 8'(wakes[0]));
    chk("pon_pos", 8'h0, pon_n);
    clear(3'h4);
    chk("cleared", 8'h0, status[2]);
    cyc(40);
    $display("test press done");
    // long hold while awake: override, supply removed
    pstate = SBW_FULL_ON;
    press = 1'b1;
    wait_flag(1, 300);
    cyc(1);
    chk("ovr_flag", 8'h1, status[1]);
    chk("ovr_pon", 8'h1, pon_n);
    chk("no_wake_on", 8'h1, 8'(wakes.size()));
    press = 1'b0;
    cyc(40);
    chk("pon_held", 8'h1, pon_n);
    chk("supply", 8'h0, pwr_ok);
    // long hold in soft-off: no override
    pstate = SBW_SOFT_OFF;
    ctrl.wake_enable = 1'b0;
    cyc(3);
    clear(3'h7);
    press = 1'b1;
    cyc(200);
    chk("soft_off_state_ovr", 8'h0, status[1]);
    chk("wake_off", 8'h1, 8'(wakes.size()));
    press = 1'b0;
    cyc(40);
    $display("test override done");
    // power enable in every state
    foreach (states[i]) begin
      pstate = states[i];
      cyc(3);
      chk(states[i].name(), 8'(exp_pon_n(states[i])), pon_n);
    end
    $display("test states done");
    // usb resume counts only in sleep
    clear(3'h7);
    pstate = SBW_STR;
    usb_rsm = 1'b1;
    cyc(4);
    usb_rsm = 1'b0;
    cyc(2);
    chk("usb_sleep", 8'h1, status[0]);
    pstate = SBW_FULL_ON;
    clear(3'h1);
    usb_rsm = 1'b1;
    cyc(4);
    usb_rsm = 1'b0;
    cyc(2);
    chk("usb_awake", 8'h0, status[0]);
    $display("test usb done");
    // pin as general io: level reaches the io path, no press, no hold
    clear(3'h7);
    ctrl.pin3_function_config = 1'b1;
    press = 1'b1;
    cyc(120);
    chk("io_level", 8'h0, gio);
    chk("io_press", 8'h0, status[2]);
    chk("io_ovr", 8'h0, status[1]);
    chk("io_supply", 8'h1, pwr_ok);
    press = 1'b0;
    cyc(3);
    chk("io_release", 8'h1, gio);
    $display("test general io done");
    // random control, thermal and pin levels
    repeat (30) begin
      ctrl = sbw_ctrl_t'($urandom());
      thermal_warning_n_n = 1'($urandom());
      press = ctrl.pin3_function_config & 1'($urandom());
      cyc(5);
      chk("throttle", 8'(ctrl.throttle_enable && !thermal_warning_n_n), thr);
      chk("ratio", 8'(ctrl.throttle_ratio), ratio);
      chk("suspend", 8'(!ctrl.suspend_ctl), susp_n);
      chk("gio", 8'(ctrl.pin3_function_config ? !press : 1'b1), gio);
    end
    $display("test random done");
    report_and_stop();
  end
endmodule
`default_nettype wire
